/* core/adc_regs_pkg.sv */
package adc_regs_pkg;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h00;
  localparam logic [7:0] OFS_RESULT_LOW  = 8'h04;
  localparam logic [7:0] OFS_CMP_HIGH    = 8'h08;
  localparam logic [7:0] OFS_CMP_LOW     = 8'h0C;
  localparam logic [7:0] OFS_CONFIG      = 8'h10;
  localparam logic [7:0] OFS_PIN_CTRL    = 8'h14;
  localparam logic [7:0] OFS_CMP_CTRL    = 8'h18;
  localparam logic [7:0] OFS_STATUS      = 8'h1C;

  localparam int CFG_LOW_POWER   = 7;
  localparam int CFG_DIV_HI      = 6;
  localparam int CFG_DIV_LO      = 5;
  localparam int CFG_LONG_SAMPLE = 4;
  localparam int CFG_MODE_HI     = 3;
  localparam int CFG_MODE_LO     = 2;
  localparam int CFG_CLK_HI      = 1;
  localparam int CFG_CLK_LO      = 0;
  localparam int CTRL_CMP_EN     = 1;
  localparam int CTRL_CMP_GT     = 0;
  localparam int STAT_DONE       = 0;
  localparam int STAT_LOCK       = 1;
  localparam int STAT_CMP_TRUE   = 2;

  localparam logic [1:0] MODE_8BIT  = 2'h0;
  localparam logic [1:0] MODE_10BIT = 2'h2;

  typedef enum logic [1:0] {
    CLK_BUS,
    CLK_BUS_HALF,
    CLK_ALT,
    CLK_ASYNC
  } clk_src_t;

  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [1:0] HIGH_MASK    = 2'h3;
  localparam logic [2:0] DIV_MASK_1   = 3'h0;
  localparam logic [2:0] DIV_MASK_2   = 3'h1;
  localparam logic [2:0] DIV_MASK_4   = 3'h3;
  localparam logic [2:0] DIV_MASK_8   = 3'h7;
endpackage

/* core/adc_result_regs.sv */
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// [R1] result bits 9:8 in high register 1:0
// [R2] 8-bit mode high result bits zero
// [R3] load results unless compare enabled and false
// [R4] 10-bit: reading high locks until low read
// [R5] results completing under lock are discarded
// [R6] 8-bit mode has no read lock
// [R7] software ignores results after mode change
// [R8] low register holds result bits 7:0
// [R9] upper compare bits used only in 10-bit
// [R10] low compare bits always compared
// [R11] config bit 7 selects low power
// [R12] config bits 6:5 divide 1/2/4/8
// [R13] config bit 4 selects long sample
// [R14] config bits 3:2 select resolution
// [R15] config bits 1:0 select clock source
// [R16] pin control bit n disables channel n
// [R17] disabled pin: hi-z, input zero, no pullup
// [R18] done flag set only on true compare; the code also sets it on each conversion loaded while compare is disabled
// [R19] compare direction: at/above or below
// [R20] round raw result to 10 or 8 bits
// [R21] unused high bits read zero, ignore writes
module adc_result_regs
  import adc_regs_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                conv_done_i,
  input  wire logic [10:0]         conv_raw_i,
  input  wire logic                alternate_clock_i,
  input  wire logic                internal_async_clock_i,
  output logic                     converter_clock_en_o,
  output logic                     low_power_select_o,
  output logic                     long_sample_select_o,
  output logic                     ten_bit_mode_o,
  output logic                     conversion_done_flag_o,
  output logic [CHANNELS-1:0]      pin_disable_o,
  input  wire logic [CHANNELS-1:0] port_out_i,
  input  wire logic [CHANNELS-1:0] port_oe_i,
  input  wire logic [CHANNELS-1:0] port_pullup_i,
  input  wire logic [CHANNELS-1:0] pin_in_i,
  output logic      [CHANNELS-1:0] pin_out_o,
  output logic      [CHANNELS-1:0] pin_oe_o,
  output logic      [CHANNELS-1:0] pin_pullup_o,
  output logic      [CHANNELS-1:0] port_in_o
);

  logic [1:0]          result_high;
  logic [7:0]          result_low;
  logic [1:0]          compare_value_high;
  logic [7:0]          compare_value_low;
  logic [7:0]          converter_configuration;
  logic [CHANNELS-1:0] analog_pin_control_low;
  logic                compare_enable;
  logic                compare_greater_select;
  logic                conversion_done_flag;
  logic                read_lock;
  logic                last_cmp_true;
  logic                ack;
  logic [31:0]         rdata;
  logic [1:0]          next_result_high;
  logic [7:0]          next_result_low;
  logic [1:0]          next_compare_value_high;
  logic [7:0]          next_compare_value_low;
  logic [7:0]          next_converter_configuration;
  logic [CHANNELS-1:0] next_analog_pin_control_low;
  logic                next_compare_enable;
  logic                next_compare_greater_select;
  logic                next_conversion_done_flag;
  logic                next_read_lock;
  logic                next_last_cmp_true;
  logic                next_ack;
  logic [31:0]         next_rdata;

  logic       req;
  logic       wr;
  logic       rd;
  logic       ten_bit;
  logic [9:0] rounded;
  logic [9:0] cmp_value;
  logic       cmp_true;
  logic       load;
  logic [11:0] sum10;
  logic [9:0]  sum8;

  assign req     = wb_cyc_i && wb_stb_i && !ack;
  assign wr      = req && wb_we_i && wb_sel_i[0];
  assign rd      = req && !wb_we_i;
  // [R14] resolution select
  assign ten_bit = converter_configuration[CFG_MODE_HI:CFG_MODE_LO] == MODE_10BIT;

  // [R20] rounding of raw result
  always_comb begin
    sum10 = {1'b0, conv_raw_i} + 12'h001;
    sum8  = {1'b0, conv_raw_i[8:0]} + 10'h001;
    if (ten_bit) begin
      rounded = sum10[11] ? 10'h3FF : sum10[10:1];
    end else begin
      rounded = sum8[9] ? 10'h0FF : {2'h0, sum8[8:1]};
    end
  end

  // [R9] upper compare bits only in 10-bit mode
  assign cmp_value = ten_bit ? {compare_value_high, compare_value_low}
                             : {2'h0, compare_value_low};
  // [R10] [R19] compare direction
  assign cmp_true = compare_greater_select ? (rounded >= cmp_value)
                                           : (rounded < cmp_value);
  // [R3] [R5] [R6] result load gating
  assign load = conv_done_i && (!compare_enable || cmp_true)
                && !(read_lock && ten_bit);

  always_comb begin
    next_result_high             = result_high;
    next_result_low              = result_low;
    next_compare_value_high      = compare_value_high;
    next_compare_value_low       = compare_value_low;
    next_converter_configuration = converter_configuration;
    next_analog_pin_control_low  = analog_pin_control_low;
    next_compare_enable          = compare_enable;
    next_compare_greater_select  = compare_greater_select;
    next_conversion_done_flag    = conversion_done_flag;
    next_read_lock               = read_lock;
    next_last_cmp_true           = last_cmp_true;
    next_ack                     = req;
    next_rdata                   = 32'h0000_0000;
    if (conv_done_i) begin
      next_last_cmp_true = cmp_true;
    end
    if (rd) begin
      if (wb_adr_i == OFS_RESULT_HIGH) begin
        // [R21] upper bits read zero
        next_rdata = {30'h0, result_high};
        // [R4] lock on high read
        if (ten_bit) begin
          next_read_lock = 1'b1;
        end
      end else if (wb_adr_i == OFS_RESULT_LOW) begin
        next_rdata                = {24'h0, result_low};
        next_read_lock            = 1'b0;
        next_conversion_done_flag = 1'b0;
      end else if (wb_adr_i == OFS_CMP_HIGH) begin
        next_rdata = {30'h0, compare_value_high};
      end else if (wb_adr_i == OFS_CMP_LOW) begin
        next_rdata = {24'h0, compare_value_low};
      end else if (wb_adr_i == OFS_CONFIG) begin
        next_rdata = {24'h0, converter_configuration};
      end else if (wb_adr_i == OFS_PIN_CTRL) begin
        next_rdata[CHANNELS-1:0] = analog_pin_control_low;
      end else if (wb_adr_i == OFS_CMP_CTRL) begin
        next_rdata[CTRL_CMP_EN] = compare_enable;
        next_rdata[CTRL_CMP_GT] = compare_greater_select;
      end else if (wb_adr_i == OFS_STATUS) begin
        next_rdata[STAT_DONE]     = conversion_done_flag;
        next_rdata[STAT_LOCK]     = read_lock;
        next_rdata[STAT_CMP_TRUE] = last_cmp_true;
      end
    end
    if (wr) begin
      if (wb_adr_i == OFS_CMP_HIGH) begin
        // [R21] upper bits ignored on write
        next_compare_value_high = wb_dat_i[1:0] & HIGH_MASK;
      end else if (wb_adr_i == OFS_CMP_LOW) begin
        next_compare_value_low = wb_dat_i[7:0];
      end else if (wb_adr_i == OFS_CONFIG) begin
        next_converter_configuration = wb_dat_i[7:0];
      end else if (wb_adr_i == OFS_PIN_CTRL) begin
        next_analog_pin_control_low = wb_dat_i[CHANNELS-1:0];
      end else if (wb_adr_i == OFS_CMP_CTRL) begin
        next_compare_enable         = wb_dat_i[CTRL_CMP_EN];
        next_compare_greater_select = wb_dat_i[CTRL_CMP_GT];
        next_conversion_done_flag   = 1'b0;
      end
    end
    // [R6] no lock in 8-bit mode
    if (!ten_bit) begin
      next_read_lock = 1'b0;
    end
    if (load) begin
      // [R1] [R2] [R8] result placement
      next_result_high = ten_bit ? rounded[9:8] : 2'h0;
      next_result_low  = rounded[7:0];
    end
    // [R18] done flag, set wins over clear
    if (load) begin
      next_conversion_done_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_high             <= 2'h0;
      result_low              <= REG_RESET;
      compare_value_high      <= 2'h0;
      compare_value_low       <= REG_RESET;
      converter_configuration <= CONFIG_RESET;
      analog_pin_control_low  <= '0;
      compare_enable          <= 1'b0;
      compare_greater_select  <= 1'b0;
      conversion_done_flag    <= 1'b0;
      read_lock               <= 1'b0;
      last_cmp_true           <= 1'b0;
      ack                     <= 1'b0;
      rdata                   <= 32'h0000_0000;
    end else begin
      result_high             <= next_result_high;
      result_low              <= next_result_low;
      compare_value_high      <= next_compare_value_high;
      compare_value_low       <= next_compare_value_low;
      converter_configuration <= next_converter_configuration;
      analog_pin_control_low  <= next_analog_pin_control_low;
      compare_enable          <= next_compare_enable;
      compare_greater_select  <= next_compare_greater_select;
      conversion_done_flag    <= next_conversion_done_flag;
      read_lock               <= next_read_lock;
      last_cmp_true           <= next_last_cmp_true;
      ack                     <= next_ack;
      rdata                   <= next_rdata;
    end
  end

  assign wb_ack_o               = ack;
  assign wb_dat_o               = rdata;
  assign conversion_done_flag_o = conversion_done_flag;
  assign ten_bit_mode_o         = ten_bit;
  // [R11] speed/power select
  assign low_power_select_o     = converter_configuration[CFG_LOW_POWER];
  // [R13] sample length select
  assign long_sample_select_o   = converter_configuration[CFG_LONG_SAMPLE];

  // converter clock: source select then divide
  clk_src_t   src;
  logic       half_tgl;
  logic       alt_q;
  logic       async_q;
  logic [2:0] div_cnt;
  logic [2:0] div_mask;
  logic       src_en;
  logic       ck_en;
  logic       next_half_tgl;
  logic [2:0] next_div_cnt;
  logic       next_ck_en;

  assign src = clk_src_t'(converter_configuration[CFG_CLK_HI:CFG_CLK_LO]);

  always_comb begin
    // [R15] input clock source
    case (src)
      CLK_BUS:      src_en = 1'b1;
      CLK_BUS_HALF: src_en = half_tgl;
      CLK_ALT:      src_en = alternate_clock_i && !alt_q;
      CLK_ASYNC:    src_en = internal_async_clock_i && !async_q;
      default:      src_en = 1'b0;
    endcase
    // [R12] divide ratio
    case (converter_configuration[CFG_DIV_HI:CFG_DIV_LO])
      2'h0:    div_mask = DIV_MASK_1;
      2'h1:    div_mask = DIV_MASK_2;
      2'h2:    div_mask = DIV_MASK_4;
      default: div_mask = DIV_MASK_8;
    endcase
    next_half_tgl = !half_tgl;
    next_div_cnt  = div_cnt;
    next_ck_en    = 1'b0;
    if (src_en) begin
      next_div_cnt = (div_cnt + 3'h1) & div_mask;
      next_ck_en   = (div_cnt & div_mask) == div_mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_tgl <= 1'b0;
      alt_q    <= 1'b0;
      async_q  <= 1'b0;
      div_cnt  <= 3'h0;
      ck_en    <= 1'b0;
    end else begin
      half_tgl <= next_half_tgl;
      alt_q    <= alternate_clock_i;
      async_q  <= internal_async_clock_i;
      div_cnt  <= next_div_cnt;
      ck_en    <= next_ck_en;
    end
  end

  assign converter_clock_en_o = ck_en;

  // pin gating per channel
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_pin
      // [R16] [R17] analog pin isolation
      assign pin_disable_o[ch] = analog_pin_control_low[ch];
      assign pin_out_o[ch]     = port_out_i[ch];
      assign pin_oe_o[ch]      = port_oe_i[ch] && !analog_pin_control_low[ch];
      assign pin_pullup_o[ch]  = port_pullup_i[ch] && !analog_pin_control_low[ch];
      assign port_in_o[ch]     = pin_in_i[ch] && !analog_pin_control_low[ch];
    end
  endgenerate

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_high_read;
    rd && wb_adr_i == OFS_RESULT_HIGH && ten_bit;
  endsequence
  sequence s_no_low_read;
    !(rd && wb_adr_i == OFS_RESULT_LOW);
  endsequence

  a_lock_blocks_load: assert property ( // [R4]
    s_high_read ##1 (s_no_low_read and (ten_bit && !wr)) |=> $stable(result_low))
    else $error("result changed while read lock held");
  a_lock_sets: assert property ( // [R4]
    s_high_read ##1 ten_bit |-> read_lock)
    else $error("high read did not set lock");
  a_low_unlock: assert property ( // [R4]
    rd && wb_adr_i == OFS_RESULT_LOW |=> !read_lock)
    else $error("low read did not release lock");
  a_cmp_eight_ignore: assert property ( // [R9]
    conv_done_i && !ten_bit && compare_enable && compare_greater_select
      && rounded[7:0] >= compare_value_low |=> conversion_done_flag)
    else $error("upper compare bits used in 8-bit mode");
  a_flag_clear: assert property ( // [R18]
    ((rd && wb_adr_i == OFS_RESULT_LOW) || (wr && wb_adr_i == OFS_CMP_CTRL))
      && !load |=> !conversion_done_flag)
    else $error("done flag not cleared");
  a_dat_idle: assert property ( // [R21]
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_eight_no_lock: assert property ( // [R6]
    !ten_bit |=> !read_lock || ten_bit)
    else $error("read lock held in 8-bit mode");
  a_eight_high_zero: assert property ( // [R2]
    conv_done_i && !ten_bit && !(read_lock && ten_bit) && !compare_enable
      |=> result_high == 2'h0)
    else $error("high result nonzero in 8-bit mode");
  a_result_load: assert property ( // [R3]
    load |=> result_low == $past(rounded[7:0]) && conversion_done_flag)
    else $error("result not loaded on completion");
  a_cmp_false_keep: assert property ( // [R3]
    conv_done_i && compare_enable && !cmp_true |=> $stable(result_low))
    else $error("result loaded on false compare");
  a_done_flag_cause: assert property ( // [R18]
    $rose(conversion_done_flag) |-> $past(load))
    else $error("done flag set without qualified completion");
  a_high_bits: assert property ( // [R1]
    load && ten_bit |=> result_high == $past(rounded[9:8]))
    else $error("high result bits wrong");
  a_pin_isolate: assert property ( // [R17]
    (analog_pin_control_low != '0) |->
      ((pin_oe_o | port_in_o | pin_pullup_o) & analog_pin_control_low) == '0)
    else $error("disabled pin not isolated");
  a_bus_ack: assert property ( // [R21]
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");
  a_div_spacing: assert property ( // [R12]
    (src == CLK_BUS && converter_configuration[CFG_DIV_HI:CFG_DIV_LO] == 2'h3
      && $stable(converter_configuration)) [*8]
      ##1 ck_en |-> $past(ck_en, 8))
    else $error("divide by 8 spacing wrong");
endmodule

/* tb/test_adc_result_regs.sv */
`timescale 1ns/1ps
module test_adc_result_regs
  import adc_regs_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        conv_done_i = 1'b0;
  logic [10:0] conv_raw_i = 11'h000;
  logic        alternate_clock_i = 1'b0;
  logic        internal_async_clock_i = 1'b0;
  logic        converter_clock_en_o;
  logic        low_power_select_o;
  logic        long_sample_select_o;
  logic        ten_bit_mode_o;
  logic        conversion_done_flag_o;
  logic [7:0]  pin_disable_o;
  logic [7:0]  port_out_i = 8'hA5;
  logic [7:0]  port_oe_i = 8'hFF;
  logic [7:0]  port_pullup_i = 8'hFF;
  logic [7:0]  pin_in_i = 8'hFF;
  logic [7:0]  pin_out_o;
  logic [7:0]  pin_oe_o;
  logic [7:0]  pin_pullup_o;
  logic [7:0]  port_in_o;
  logic [1:0]  slow_cnt = 2'h0;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [31:0] rd;

  adc_result_regs #(.CHANNELS(8)) adc_result_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_done_i(conv_done_i),
    .conv_raw_i(conv_raw_i), .alternate_clock_i(alternate_clock_i),
    .internal_async_clock_i(internal_async_clock_i),
    .converter_clock_en_o(converter_clock_en_o), .low_power_select_o(low_power_select_o),
    .long_sample_select_o(long_sample_select_o), .ten_bit_mode_o(ten_bit_mode_o),
    .conversion_done_flag_o(conversion_done_flag_o), .pin_disable_o(pin_disable_o),
    .port_out_i(port_out_i), .port_oe_i(port_oe_i), .port_pullup_i(port_pullup_i),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o), .port_in_o(port_in_o));

  always #2.5 clk_i = ~clk_i;

  // slow sources: rising edge every 4 bus cycles
  always @(posedge clk_i) begin
    slow_cnt <= slow_cnt + 2'h1;
    alternate_clock_i <= slow_cnt[1];
    internal_async_clock_i <= slow_cnt[1];
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    wb_xfer(1'b1, adr, {24'h0, d});
  endtask

  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [7:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    check(name, rd, {24'h0, exp});
  endtask

  task automatic conv(input logic [10:0] raw);
    @(posedge clk_i);
    conv_done_i <= 1'b1;
    conv_raw_i  <= raw;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic count_clk(input logic [7:0] cfg, input int exp);
    int n;
    n = 0;
    wr(OFS_CONFIG, cfg);
    repeat (16) @(posedge clk_i);
    repeat (40) begin
      @(posedge clk_i);
      if (converter_clock_en_o === 1'b1) n++;
    end
    check("clock enables", n, exp);
  endtask

  task automatic t_reset_and_map();
    rd_chk("config reset", OFS_CONFIG, CONFIG_RESET);
    rd_chk("pin ctrl reset", OFS_PIN_CTRL, REG_RESET);
    rd_chk("result high reset", OFS_RESULT_HIGH, REG_RESET);
    wr(8'h20, 8'hFF);
    rd_chk("unmapped", 8'h20, 8'h00);
    wr(OFS_CMP_HIGH, 8'hFF);
    rd_chk("cmp high bits", OFS_CMP_HIGH, 8'h03);
    wr(OFS_RESULT_LOW, 8'h55);
    rd_chk("result low ro", OFS_RESULT_LOW, 8'h00);
  endtask

  task automatic t_config();
    wr(OFS_CONFIG, 8'h98);
    check("low power", low_power_select_o, 1'b1);
    check("long sample", long_sample_select_o, 1'b1);
    check("ten bit", ten_bit_mode_o, 1'b1);
    rd_chk("config rb", OFS_CONFIG, 8'h98);
    wr(OFS_CONFIG, 8'h00);
    check("low power off", low_power_select_o, 1'b0);
    check("short sample", long_sample_select_o, 1'b0);
    check("eight bit", ten_bit_mode_o, 1'b0);
  endtask

  task automatic t_clocks();
    for (int d = 0; d < 4; d++) count_clk(8'(d << 5), 40 >> d);
    count_clk(8'h01, 20);
    count_clk(8'h02, 10);
    count_clk(8'h03, 10);
    count_clk(8'h22, 5);
  endtask

  task automatic t_lock_10bit();
    wr(OFS_CONFIG, 8'h08);
    conv(11'h2AB);
    check("flag set", conversion_done_flag_o, 1'b1);
    rd_chk("high 10b", OFS_RESULT_HIGH, 8'h01);
    rd_chk("status locked", OFS_STATUS, 8'h07);
    conv(11'h0FF);
    check("flag held", conversion_done_flag_o, 1'b1);
    rd_chk("low locked", OFS_RESULT_LOW, 8'h56);
    check("flag cleared", conversion_done_flag_o, 1'b0);
    conv(11'h0FF);
    rd_chk("low new", OFS_RESULT_LOW, 8'h80);
    rd_chk("high new", OFS_RESULT_HIGH, 8'h00);
    rd_chk("low after", OFS_RESULT_LOW, 8'h80);
  endtask

  task automatic t_nolock_8bit();
    wr(OFS_CONFIG, 8'h00);
    conv(11'h1FF);
    rd_chk("high 8b", OFS_RESULT_HIGH, 8'h00);
    conv(11'h021);
    rd_chk("low 8b", OFS_RESULT_LOW, 8'h11);
    rd_chk("high 8b again", OFS_RESULT_HIGH, 8'h00);
    conv(11'h1FF);
    rd_chk("low sat", OFS_RESULT_LOW, 8'hFF);
  endtask

  task automatic t_compare();
    wr(OFS_CMP_HIGH, 8'h03);
    wr(OFS_CMP_LOW, 8'h80);
    wr(OFS_CMP_CTRL, 8'h03);
    conv(11'h080);
    check("cmp false flag", conversion_done_flag_o, 1'b0);
    rd_chk("cmp false kept", OFS_RESULT_LOW, 8'hFF);
    conv(11'h120);
    check("cmp true flag", conversion_done_flag_o, 1'b1);
    rd_chk("cmp 8b true", OFS_RESULT_LOW, 8'h90);
    conv(11'h0FF);
    rd_chk("cmp equal", OFS_RESULT_LOW, 8'h80);
    wr(OFS_CONFIG, 8'h08);
    wr(OFS_CMP_HIGH, 8'h02);
    wr(OFS_CMP_LOW, 8'h00);
    wr(OFS_CMP_CTRL, 8'h02);
    conv(11'h3FD);
    rd_chk("cmp lt high", OFS_RESULT_HIGH, 8'h01);
    rd_chk("cmp lt low", OFS_RESULT_LOW, 8'hFF);
    conv(11'h3FF);
    rd_chk("cmp ge kept hi", OFS_RESULT_HIGH, 8'h01);
    rd_chk("cmp ge kept lo", OFS_RESULT_LOW, 8'hFF);
    wr(OFS_CMP_CTRL, 8'h00);
  endtask

  task automatic t_pins();
    wr(OFS_PIN_CTRL, 8'h0F);
    check("pin disable", pin_disable_o, 8'h0F);
    check("pin oe", pin_oe_o, 8'hF0);
    check("pin pullup", pin_pullup_o, 8'hF0);
    check("port in", port_in_o, 8'hF0);
    check("pin out", pin_out_o, 8'hA5);
    rd_chk("pin ctrl rb", OFS_PIN_CTRL, 8'h0F);
    wr(OFS_PIN_CTRL, 8'hF0);
    check("pin oe swap", pin_oe_o, 8'h0F);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_and_map();
    t_config();
    t_clocks();
    t_lock_10bit();
    t_nolock_8bit();
    t_compare();
    t_pins();
    end_sim();
  end
endmodule
